// >>> rtl/remote_io_satellite_core.sv
// remote i/o satellite core: sense/drive words, link-alive monitor, force-low filter
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "remote_io_defs.svh"
module remote_io_satellite_core
  import remote_io_pkg::*;
#(
  parameter int MON_BITS = `MON_TIMEOUT_BITS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] sense_inputs_in,
  input  wire logic [5:0]  station_id_pins_in,
  input  wire logic        rate_select_lo_in,
  input  wire logic        rate_select_hi_in,
  input  wire logic        force_low_in,
  input  wire logic        frame_valid_in,
  input  wire logic        frame_error_in,
  input  wire logic [5:0]  frame_addr_in,
  input  wire logic [3:0]  frame_cmd_in,
  input  wire logic [15:0] frame_data_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [15:0] drive_outputs_out,
  output logic      [15:0] reply_data_out,
  output logic             reply_valid_out,
  output logic             sample_strobe_out,
  output logic             link_alive_n_out,
  output logic             irq_out
);
  // reset is synchronous, so a glitch between two edges is never seen
  rate_t        rate;
  logic [7:0]   bit_cycles;
  logic [7:0]   bit_cnt_reg;
  logic         bit_tick;
  logic [5:0]   station_number;
  logic         self_frame;
  logic         sample_cmd;
  logic [7:0]   force_cnt_reg;
  logic         force_active_reg;
  logic [16:0]  mon_cnt_reg;
  logic         mon_expire;
  logic [15:0]  drive_reg;
  logic [15:0]  reply_reg;
  logic         reply_valid_reg;
  logic         strobe_reg;
  logic         alive_n_reg;
  logic [3:0]   int_stat_reg;
  logic [3:0]   int_stat_next;
  logic [3:0]   int_mask_reg;
  logic [3:0]   int_event;
  logic [3:0]   w1c;
  logic         sw_hold_reg;
  logic         apb_write;
  logic         apb_read;
  logic [31:0]  rd_mux;
  logic         rd_hit;

  function automatic logic [7:0] cycles_for(input rate_t r);
    unique case (r)
      rate_12m_t_v: cycles_for = 8'(`BIT_CYC_12M);
      rate_6m_t_v:  cycles_for = 8'(`BIT_CYC_6M);
      rate_3m_t_v:  cycles_for = 8'(`BIT_CYC_3M);
      rate_1m5_t_v: cycles_for = 8'(`BIT_CYC_1M5);
    endcase
  endfunction

  assign rate           = rate_t'({rate_select_hi_in, rate_select_lo_in});
  assign bit_cycles     = cycles_for(rate);
  assign bit_tick       = (bit_cnt_reg >= bit_cycles - 8'h01);
  assign station_number = station_id_pins_in;
  // address 00h never matches: such a station is never polled
  assign self_frame     = frame_valid_in && !frame_error_in && (station_number != 6'h00)
                          && (frame_addr_in == station_number);
  assign sample_cmd     = (frame_cmd_in == `CMD_SAMPLE_A) || (frame_cmd_in == `CMD_SAMPLE_B);
  assign mon_expire     = (mon_cnt_reg >= 17'(MON_BITS)) && !alive_n_reg;

  // bit period divider
  always_ff @(posedge clk_in) begin
    if (rst_in || bit_tick) begin
      bit_cnt_reg <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 8'h01;
    end
  end

  // force-low filter: must stay high for a whole bit period before it acts
  always_ff @(posedge clk_in) begin
    if (rst_in || !force_low_in) begin
      force_cnt_reg <= 8'h00;
    end else if (force_cnt_reg < bit_cycles) begin
      force_cnt_reg <= force_cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      force_active_reg <= 1'b0;
    end else begin
      force_active_reg <= force_low_in && (force_cnt_reg >= bit_cycles - 8'h01);
    end
  end

  // drive word: cleared by reset or filtered force-low, loaded from a good self-addressed frame unless software hold is set, otherwise held
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_reg <= 16'h0000;
    end else if (force_active_reg) begin
      drive_reg <= 16'h0000;
    end else if (self_frame && !sw_hold_reg) begin
      drive_reg <= frame_data_in;
    end
    // no clearing on timeout
  end
  assign drive_outputs_out = drive_reg;

  // reply data and sample strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reply_reg       <= 16'h0000;
      reply_valid_reg <= 1'b0;
      strobe_reg      <= 1'b0;
    end else begin
      reply_valid_reg <= self_frame;
      strobe_reg      <= self_frame && sample_cmd;
      if (self_frame) begin
        reply_reg <= sample_cmd ? sense_inputs_in : `NO_SAMPLE_DATA;
      end
    end
  end
  assign reply_data_out    = reply_reg;
  assign reply_valid_out   = reply_valid_reg;
  assign sample_strobe_out = strobe_reg;

  // link-alive monitor: retriggerable one-shot counted in bit periods
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alive_n_reg <= 1'b1;
      mon_cnt_reg <= 17'h00000;
    end else if (self_frame) begin
      alive_n_reg <= 1'b0;
      mon_cnt_reg <= 17'h00000;
    end else if (mon_expire) begin
      alive_n_reg <= 1'b1;
    end else if (bit_tick && !alive_n_reg) begin
      mon_cnt_reg <= mon_cnt_reg + 17'h00001;
    end
  end
  assign link_alive_n_out = alive_n_reg;

  // interrupts: sticky, set wins over write-one-to-clear
  assign int_event = {self_frame && sample_cmd, force_active_reg, mon_expire, self_frame};
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && penable && !pwrite;
  assign w1c       = (apb_write && paddr == `REG_INT_STAT) ? pwdata[3:0] : 4'h0;
  assign int_stat_next = int_event | (int_stat_reg & ~w1c);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      int_stat_reg <= 4'h0;
      int_mask_reg <= 4'h0;
      sw_hold_reg  <= 1'b0;
    end else begin
      int_stat_reg <= int_stat_next;
      if (apb_write && paddr == `REG_INT_MASK) begin
        int_mask_reg <= pwdata[3:0];
      end
      if (apb_write && paddr == `REG_CTRL) begin
        sw_hold_reg <= pwdata[0];
      end
    end
  end
  assign irq_out = |(int_stat_reg & int_mask_reg);

  // apb slave: zero wait states, error on unmapped address
  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr)
      `REG_CTRL:     rd_mux = {31'h0, sw_hold_reg};
      `REG_STATUS:   rd_mux = {22'h0, rate, station_number, force_active_reg, alive_n_reg};
      `REG_INT_STAT: rd_mux = {28'h0, int_stat_reg};
      `REG_INT_MASK: rd_mux = {28'h0, int_mask_reg};
      `REG_DRIVE:    rd_mux = {16'h0, drive_reg};
      `REG_SENSE:    rd_mux = {16'h0, sense_inputs_in};
      `REG_REPLY:    rd_mux = {16'h0, reply_reg};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // link-alive falls the cycle after a good self-addressed frame
  alive_low_a: assert property (@(posedge clk_in) disable iff (rst_in)
    self_frame |=> !link_alive_n_out) else $error("link alive not low after frame");
  // drive word follows frame data unless forced or held by software
  drive_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    self_frame && !force_active_reg && !sw_hold_reg |=> drive_outputs_out == $past(frame_data_in))
    else $error("drive word not loaded");
  drive_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !self_frame && !force_active_reg |=> $stable(drive_outputs_out))
    else $error("drive word changed without cause");
  force_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
    force_active_reg |=> drive_outputs_out == 16'h0000) else $error("force low not applied");
  glitch_reject_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(force_low_in) ##1 !force_low_in |=> !force_active_reg)
    else $error("short force pulse acted");
  reply_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    self_frame && !sample_cmd |=> reply_data_out == 16'h0000 && !sample_strobe_out)
    else $error("reply not zero");
  reply_sense_a: assert property (@(posedge clk_in) disable iff (rst_in)
    self_frame && sample_cmd |=> reply_data_out == $past(sense_inputs_in) && sample_strobe_out)
    else $error("reply missing sense word");
  reset_state_a: assert property (@(posedge clk_in)
    rst_in |=> drive_outputs_out == 16'h0000 && link_alive_n_out)
    else $error("reset state wrong");

  // a good self-addressed frame always produces a reply pulse
  reply_valid_a: assert property (@(posedge clk_in) disable iff (rst_in)
    self_frame |=> reply_valid_out)
    else $error("reply valid missing");

  // no reply without a good self-addressed frame
  no_reply_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !self_frame |=> !reply_valid_out)
    else $error("spurious reply valid");

  // the sample strobe only follows commands 0 and 8
  strobe_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !(self_frame && sample_cmd) |=> !sample_strobe_out)
    else $error("spurious sample strobe");

  // a strobe never stands without its reply
  strobe_reply_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sample_strobe_out |-> reply_valid_out)
    else $error("strobe without reply");

  // a frame with an error leaves the drive word alone
  error_frame_a: assert property (@(posedge clk_in) disable iff (rst_in)
    frame_valid_in && frame_error_in && !force_active_reg |=> $stable(drive_outputs_out))
    else $error("errored frame changed drive word");

  // link-alive stays low while the interval runs
  alive_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !self_frame && !mon_expire && !alive_n_reg |=> !link_alive_n_out)
    else $error("link alive rose early");

  // link-alive goes high once the interval has run out
  alive_expire_a: assert property (@(posedge clk_in) disable iff (rst_in)
    mon_expire && !self_frame |=> link_alive_n_out)
    else $error("link alive did not time out");

  // the interval counter never runs past its end point
  mon_bound_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !alive_n_reg |-> mon_cnt_reg <= 17'(MON_BITS))
    else $error("monitor count overran");

  // link-alive only rises through a timeout
  alive_rise_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(link_alive_n_out) |-> $past(mon_expire))
    else $error("link alive rose without timeout");

  // an idle high link-alive stays high until a frame arrives
  alive_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    link_alive_n_out && !self_frame |=> link_alive_n_out)
    else $error("link alive fell without frame");

  // the filter drops on the clock edge after force-low goes away
  force_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !force_low_in |=> !force_active_reg)
    else $error("force filter active while input low");

  // reset also silences the reply side and the interrupt
  reset_quiet_a: assert property (@(posedge clk_in)
    rst_in |=> !reply_valid_out && !sample_strobe_out && !irq_out)
    else $error("reply side busy after reset");
endmodule

// >>> rtl/remote_io_defs.svh
// constants for the remote i/o satellite core
`ifndef REMOTE_IO_DEFS_SVH
`define REMOTE_IO_DEFS_SVH
`define CLK_FREQ_HZ        100000000
`define BIT_RATE_12M       12000000
`define BIT_RATE_6M        6000000
`define BIT_RATE_3M        3000000
`define BIT_RATE_1M5       1500000
`define BIT_CYC_12M        (`CLK_FREQ_HZ / `BIT_RATE_12M)
`define BIT_CYC_6M         (`CLK_FREQ_HZ / `BIT_RATE_6M)
`define BIT_CYC_3M         (`CLK_FREQ_HZ / `BIT_RATE_3M)
`define BIT_CYC_1M5        (`CLK_FREQ_HZ / `BIT_RATE_1M5)
`define MON_TIMEOUT_BITS   130560
`define CMD_SAMPLE_A       4'h0
`define CMD_SAMPLE_B       4'h8
`define NO_SAMPLE_DATA     16'h0000
`define REG_CTRL           12'h000
`define REG_STATUS         12'h004
`define REG_INT_STAT       12'h008
`define REG_INT_MASK       12'h00c
`define REG_DRIVE          12'h010
`define REG_SENSE          12'h014
`define REG_REPLY          12'h018
`define INT_UPDATE_BIT     0
`define INT_TIMEOUT_BIT    1
`define INT_FORCE_BIT      2
`define INT_SAMPLE_BIT     3
`endif

// >>> rtl/remote_io_pkg.sv
// types for the remote i/o satellite core
package remote_io_pkg;
  typedef enum logic [1:0] {
    rate_1m5_t_v = 2'b00,
    rate_3m_t_v  = 2'b01,
    rate_6m_t_v  = 2'b10,
    rate_12m_t_v = 2'b11
  } rate_t;
endpackage

// >>> bench/center_model.sv
// center controller model: hands decoded request frames to the core
`timescale 1ns/10ps
module center_model (
  input  wire logic        clk_in,
  output logic             valid_out,
  output logic             error_out,
  output logic [5:0]       addr_out,
  output logic [3:0]       cmd_out,
  output logic [15:0]      data_out
);
  initial begin
    valid_out = 1'b0;
    error_out = 1'b0;
    addr_out  = 6'h3f;
    cmd_out   = 4'hf;
    data_out  = 16'hffff;
  end
  // one frame per call, so frames never overlap
  task automatic send(input logic [5:0] a, input logic [3:0] c, input logic [15:0] d,
                      input logic e);
    @(posedge clk_in);
    valid_out <= 1'b1;
    error_out <= e;
    addr_out  <= a;
    cmd_out   <= c;
    data_out  <= d;
    @(posedge clk_in);
    valid_out <= 1'b0;
    // released fields show garbage, never the stale frame
    addr_out  <= ~a;
    cmd_out   <= ~c;
    data_out  <= ~d;
  endtask
endmodule

// >>> bench/testbench.sv
// self-checking bench for the remote i/o satellite core
`timescale 1ns/10ps
module testbench;
  import remote_io_pkg::*;
  localparam int MON_BITS = 20;
  logic clk_in = 1'b0, rst_in = 1'b1, force_low_in = 1'b0;
  logic [15:0] sense_inputs_in = 16'h0000;
  logic [5:0] station_id_pins_in = 6'h2a;
  logic rate_select_lo_in = 1'b1, rate_select_hi_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, st = 32'd62;
  logic pready, pslverr, reply_valid_out, sample_strobe_out, link_alive_n_out, irq_out, err;
  logic frame_valid_in, frame_error_in;
  logic [5:0] frame_addr_in;
  logic [3:0] frame_cmd_in;
  logic [15:0] frame_data_in, drive_outputs_out, reply_data_out;
  int failures = 0, check_count = 0, n, hold = 0;
  int hist[$];
  int bc[4] = '{66, 33, 16, 8};
  always #5 clk_in = ~clk_in;
  remote_io_satellite_core #(.MON_BITS(MON_BITS)) i_dut (.*);
  center_model i_cc (
    .clk_in    (clk_in),
    .valid_out (frame_valid_in),
    .error_out (frame_error_in),
    .addr_out  (frame_addr_in),
    .cmd_out   (frame_cmd_in),
    .data_out  (frame_data_in)
  );
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do @(posedge clk_in); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic frame(input logic [5:0] a, input logic [3:0] c, input logic e);
    logic [15:0] d;
    logic hit;
    d = 16'(xs());
    hit = !e && a == station_id_pins_in && a != 6'h00;
    @(posedge clk_in);
    sense_inputs_in <= 16'(xs());
    if (hit && hold == 0) hist.push_back(d);
    i_cc.send(a, c, d, e);
    #1;
    check("drive", drive_outputs_out, hist[$]);
    check("reply_valid", reply_valid_out, hit);
    if (hit) begin
      check("reply", reply_data_out, (c == 4'h0 || c == 4'h8) ? sense_inputs_in : 0);
      check("strobe", sample_strobe_out, c == 4'h0 || c == 4'h8);
      check("alive", link_alive_n_out, 0);
    end
  endtask
  task automatic results();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500us;
    failures++;
    results();
  end
  initial begin
    hist.push_back(0);
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1;
    check("rst_drive", drive_outputs_out, 0);
    check("rst_alive", link_alive_n_out, 1);
    apb(1'b1, 12'h00c, 32'h1);
    for (int c = 0; c < 15; c++) frame(station_id_pins_in, 4'(c), 1'b0);
    check("irq_set", irq_out, 1);
    apb(1'b1, 12'h008, 32'hf);
    #1;
    check("irq_clr", irq_out, 0);
    apb(1'b1, 12'h000, 32'h1);
    hold = 1;
    frame(station_id_pins_in, 4'h8, 1'b0);
    hold = 0;
    apb(1'b1, 12'h000, 32'h0);
    $display("test commands done");
    frame(station_id_pins_in ^ 6'h01, 4'h0, 1'b0);
    frame(station_id_pins_in, 4'h0, 1'b1);
    @(posedge clk_in);
    station_id_pins_in <= 6'h00;
    frame(6'h00, 4'h0, 1'b0);
    station_id_pins_in <= 6'h15;
    apb(1'b0, 12'h014, 32'h0);
    check("sense_reg", rd, {16'h0, sense_inputs_in});
    apb(1'b0, 12'h004, 32'h0);
    check("status", rd[31:1], {22'h0, 2'b11, 6'h15, 1'b0});
    apb(1'b0, 12'hff0, 32'h0);
    check("unmapped", {err, rd}, {1'b1, 32'h0});
    $display("test filtering done");
    // the monitor tick phase is free, so one bit period of slack each side
    for (int r = 0; r < 4; r++) begin
      @(posedge clk_in);
      {rate_select_hi_in, rate_select_lo_in} <= 2'(r);
      frame(6'h15, 4'h8, 1'b0);
      for (n = 0; n < 2000 && link_alive_n_out !== 1'b1; n++) @(posedge clk_in);
      check("timeout", n inside {[(MON_BITS - 1) * bc[r] : (MON_BITS + 1) * bc[r] + 2]}, 1);
      check("held", drive_outputs_out, hist[$]);
    end
    $display("test monitor done");
    @(posedge clk_in);
    force_low_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    force_low_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    check("glitch", drive_outputs_out, hist[$]);
    force_low_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    #1;
    check("forced", drive_outputs_out, 0);
    force_low_in <= 1'b0;
    hist.push_back(0);
    repeat (12) @(posedge clk_in);
    check("discard", drive_outputs_out, 0);
    $display("test force done");
    results();
  end
endmodule
